/* design/rxesb_top.sv */
// receive elastic slip buffer with apb registers and slot translation
`timescale 1ns/1ps
module rxesb_top #(
    parameter int SLIP_LIMIT = rxesb_pkg::RXESB_SLIP_LIMIT
) (
    input wire logic MCLK,                    // block clock, 100 MHz
    input wire logic SYS_RST,                 // async reset, high
    input wire logic PSEL,                    // apb select
    input wire logic PENABLE,                 // apb access phase
    input wire logic PWRITE,                  // apb direction
    input wire logic [7:0] PADDR,             // apb byte address
    input wire logic [31:0] PWDATA,           // apb write data
    output logic [31:0] PRDATA,               // apb read data
    output logic PREADY,                      // apb ready
    output logic PSLVERR,                     // apb error, unmapped address
    input wire logic RX_ROUTE_CLK,            // recovered line clock
    input wire logic RX_LINE_DATA,            // unipolar line data
    input wire logic RX_SYSTEM_CLOCK,         // system highway clock
    input wire logic RX_FRAME_SYNC_PULSE_I,   // sync pin level in
    output logic RX_FRAME_SYNC_PULSE_O,       // sync pin level out
    output logic RX_FRAME_SYNC_PULSE_OE,      // sync pin driven
    output logic RX_DATA_OUT,                 // serial system data
    output logic RX_SLIP_IRQ                  // level interrupt
);
    import rxesb_pkg::*;

    if (SLIP_LIMIT < 1 || SLIP_LIMIT >= 48) begin : g_bad_limit
        $error("rxesb_top: slip limit must lie in 1..47");
    end

    function automatic logic [8:0] size_bits(input logic [1:0] sel);
        unique case (rxesb_size_e'(sel))
            RXESB_SZ_TWO: size_bits = RXESB_BITS_TWO;
            RXESB_SZ_ONE: size_bits = RXESB_BITS_ONE;
            RXESB_SZ_SHORT: size_bits = RXESB_BITS_SHORT;
            RXESB_SZ_BYPASS: size_bits = RXESB_BITS_SHORT;
        endcase
    endfunction : size_bits

    function automatic logic [8:0] ptr_step(input logic [8:0] p, input logic [8:0] size);
        ptr_step = (p >= size - 9'd1) ? 9'd0 : p + 9'd1;
    endfunction : ptr_step

    // distance from b forward to a around the ring
    function automatic logic [8:0] ptr_dist(input logic [8:0] a, input logic [8:0] b,
                                            input logic [8:0] size);
        ptr_dist = (a >= b) ? a - b : a + size - b;
    endfunction : ptr_dist

    // line channel carried by a system slot, 0 = framing bit
    function automatic logic [4:0] chan_of_slot(input logic [4:0] slot, input logic ctm);
        logic [4:0] c;
        c = RXESB_CHAN_NONE;
        if (slot == RXESB_FS_SLOT) begin
            c = RXESB_CHAN_FS;
        end else if (ctm) begin
            if (slot <= RXESB_LAST_EQUIP_M1) begin
                c = slot;
            end
        end else if (slot[1:0] != 2'b00) begin
            c = slot - {2'b00, slot[4:2]};
        end
        chan_of_slot = c;
    endfunction : chan_of_slot

    // inputs from outside the clock domain
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic route_rise;
    logic line_bit;
    logic sys_rise;
    logic sync_rise;

    rxesb_sync #(.W(4)) u_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .din({RX_FRAME_SYNC_PULSE_I, RX_SYSTEM_CLOCK, RX_LINE_DATA, RX_ROUTE_CLK}),
        .dout(pin_lvl),
        .rise(pin_rise)
    );

    assign route_rise = pin_rise[0];
    assign line_bit = pin_lvl[1];
    assign sys_rise = pin_rise[2];
    assign sync_rise = pin_rise[3];

    // register state
    logic [3:0] ctrl_q;
    logic [7:0] ofs_low_q;
    logic [1:0] ofs_high_q;
    logic [1:0] int_status_q;
    logic [1:0] int_mask_q;
    logic [7:0] pos_count_q;
    logic [7:0] neg_count_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;

    logic [1:0] size_sel;
    logic bypass;
    logic ctm;
    logic sync_out;
    logic [8:0] buf_size;
    logic [8:0] half;

    assign size_sel = ctrl_q[RXESB_CTRL_SIZE_LSB +: 2];
    assign bypass = (rxesb_size_e'(size_sel) == RXESB_SZ_BYPASS);
    assign ctm = ctrl_q[RXESB_CTRL_CTM_BIT];
    assign sync_out = ctrl_q[RXESB_CTRL_SYNC_OUT_BIT];
    assign buf_size = size_bits(size_sel);
    assign half = buf_size >> 1;

    // apb decode
    logic setup;
    logic wr_en;
    logic mapped;

    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PWRITE && pready_q && !pslverr_q;
    assign mapped = (PADDR == RXESB_REG_CTRL) || (PADDR == RXESB_REG_OFS_LOW)
                 || (PADDR == RXESB_REG_OFS_HIGH) || (PADDR == RXESB_REG_INT_STATUS)
                 || (PADDR == RXESB_REG_INT_MASK) || (PADDR == RXESB_REG_PTR_STATUS)
                 || (PADDR == RXESB_REG_SLIP_COUNT);

    // buffer pointers
    logic [8:0] wr_ptr_q;
    logic [8:0] rd_ptr_q;
    logic [1:0] size_prev_q;
    logic mem_bit;
    logic [8:0] rd_next;
    logic [8:0] gap;
    logic slip_pos;
    logic slip_neg;

    // read side timing
    logic [7:0] sys_bit_q;
    logic [7:0] sys_bit_d;
    logic [4:0] chan;
    logic consume;
    logic data_q;
    logic sync_o_q;
    logic sync_out_q;

    always_comb begin
        sys_bit_d = sys_bit_q + 8'd1;
        // frame start from sync and offset
        if (sync_rise && !sync_out) begin
            sys_bit_d = ofs_low_q;
        end
    end

    assign chan = chan_of_slot(sys_bit_d[7:3], ctm);
    // framing bit in slot 0, channels only in slots that chan_of_slot maps
    assign consume = !bypass && sys_rise && (chan != RXESB_CHAN_NONE)
                  && ((chan != RXESB_CHAN_FS) || (sys_bit_d[2:0] == RXESB_FS_BIT));
    assign rd_next = ptr_step(rd_ptr_q, buf_size);
    assign gap = ptr_dist(wr_ptr_q, rd_next, buf_size);
    // slip window, never in bypass or mid-resize
    assign slip_pos = consume && (size_prev_q == size_sel) && (gap < 9'(SLIP_LIMIT));
    assign slip_neg = consume && (size_prev_q == size_sel) && (gap > buf_size - 9'(SLIP_LIMIT));

    rxesb_mem #(.DEPTH(RXESB_MAX_BITS), .AW(RXESB_PTR_W)) u_mem (
        .clk(MCLK),
        .we(route_rise && !bypass),
        .waddr(wr_ptr_q),
        .wdata(line_bit),
        .raddr(rd_ptr_q),
        .rdata(mem_bit)
    );

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            size_prev_q <= RXESB_CTRL_RST[1:0];
            wr_ptr_q <= '0;
        end else begin
            size_prev_q <= size_sel;
            if (size_prev_q != size_sel) begin
                wr_ptr_q <= '0;
            end else if (route_rise && !bypass) begin
                wr_ptr_q <= ptr_step(wr_ptr_q, buf_size);
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_ptr_q <= '0;
        end else if (size_prev_q != size_sel) begin
            rd_ptr_q <= buf_size - half;
        end else if (slip_pos || slip_neg) begin
            // jump to half a buffer behind write
            rd_ptr_q <= ptr_dist(wr_ptr_q, half, buf_size);
        end else if (consume) begin
            rd_ptr_q <= rd_next;
        end
    end

    // system bit counter, sync ignored in bypass
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sys_bit_q <= '0;
        end else if (sys_rise && !bypass) begin
            sys_bit_q <= sys_bit_d;
        end
    end

    // sync as output when software selects it
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_o_q <= 1'b0;
        end else if (sys_rise && !bypass) begin
            sync_o_q <= (sys_bit_d == 8'h00);
        end else if (bypass) begin
            sync_o_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            data_q <= 1'b1;
        end else if (bypass) begin
            if (route_rise) begin
                data_q <= line_bit;
            end
        end else if (sys_rise) begin
            // unequipped slots and framing padding read ones
            if (consume) begin
                data_q <= mem_bit;
            end else begin
                data_q <= RXESB_UNEQUIPPED[sys_bit_d[2:0]];
            end
        end
    end

    // sticky flags, set beats write-one clear
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            int_status_q <= '0;
        end else begin
            int_status_q <= (int_status_q
                             & ~((wr_en && PADDR == RXESB_REG_INT_STATUS) ? PWDATA[1:0] : 2'b00))
                          | {slip_neg, slip_pos};
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pos_count_q <= '0;
            neg_count_q <= '0;
        end else begin
            if (slip_pos) begin
                pos_count_q <= pos_count_q + 8'd1;
            end
            if (slip_neg) begin
                neg_count_q <= neg_count_q + 8'd1;
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_status_q & ~int_mask_q);
        end
    end

    // software-written control
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_q <= RXESB_CTRL_RST;
            ofs_low_q <= RXESB_OFS_LOW_RST;
            ofs_high_q <= RXESB_OFS_HIGH_RST;
            int_mask_q <= RXESB_INT_MASK_RST;
        end else if (wr_en) begin
            if (PADDR == RXESB_REG_CTRL) begin
                ctrl_q <= PWDATA[3:0];
            end
            if (PADDR == RXESB_REG_OFS_LOW && !bypass) begin
                ofs_low_q <= PWDATA[7:0];
            end
            if (PADDR == RXESB_REG_OFS_HIGH && !bypass) begin
                ofs_high_q <= PWDATA[1:0];
            end
            if (PADDR == RXESB_REG_INT_MASK) begin
                int_mask_q <= PWDATA[1:0];
            end
        end
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            if (setup && !PWRITE) begin
                prdata_q <= '0;
                unique case (PADDR)
                    RXESB_REG_CTRL: prdata_q[3:0] <= ctrl_q;
                    RXESB_REG_OFS_LOW: prdata_q[7:0] <= ofs_low_q;
                    RXESB_REG_OFS_HIGH: prdata_q[1:0] <= ofs_high_q;
                    RXESB_REG_INT_STATUS: prdata_q[1:0] <= int_status_q;
                    RXESB_REG_INT_MASK: prdata_q[1:0] <= int_mask_q;
                    RXESB_REG_PTR_STATUS: begin
                        prdata_q[8:0] <= wr_ptr_q;
                        prdata_q[RXESB_PTR_RD_LSB +: 9] <= rd_ptr_q;
                    end
                    RXESB_REG_SLIP_COUNT: prdata_q[15:0] <= {neg_count_q, pos_count_q};
                    default: prdata_q <= '0;
                endcase
            end
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign RX_DATA_OUT = data_q;
    assign RX_SLIP_IRQ = irq_q;
    assign RX_FRAME_SYNC_PULSE_O = sync_o_q;
    assign RX_FRAME_SYNC_PULSE_OE = sync_out_q;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_out_q <= 1'b0;
        end else begin
            sync_out_q <= sync_out;
        end
    end
endmodule : rxesb_top

/* design/rxesb_pkg.sv */
// shared constants and types for the receive elastic slip buffer
package rxesb_pkg;

    typedef enum logic [1:0] {
        RXESB_SZ_TWO = 2'b00,
        RXESB_SZ_ONE = 2'b01,
        RXESB_SZ_SHORT = 2'b10,
        RXESB_SZ_BYPASS = 2'b11
    } rxesb_size_e;

    // buffer depths in bits
    localparam logic [8:0] RXESB_BITS_TWO = 9'd386;
    localparam logic [8:0] RXESB_BITS_ONE = 9'd193;
    localparam logic [8:0] RXESB_BITS_SHORT = 9'd96;
    localparam int RXESB_MAX_BITS = 386;
    localparam int RXESB_PTR_W = 9;

    // frame geometry
    localparam int RXESB_LINE_CHANS = 24;
    localparam int RXESB_SYS_SLOTS = 32;
    localparam logic [4:0] RXESB_FS_SLOT = 5'd0;
    localparam logic [4:0] RXESB_CHAN_NONE = 5'd25;
    localparam logic [4:0] RXESB_CHAN_FS = 5'd0;
    localparam logic [4:0] RXESB_LAST_EQUIP_M1 = 5'd24;
    localparam logic [7:0] RXESB_UNEQUIPPED = 8'hFF;
    localparam logic [2:0] RXESB_FS_BIT = 3'h0;
    localparam int RXESB_SLIP_LIMIT = 8;

    // register byte offsets
    localparam logic [7:0] RXESB_REG_CTRL = 8'h00;
    localparam logic [7:0] RXESB_REG_OFS_LOW = 8'h04;
    localparam logic [7:0] RXESB_REG_OFS_HIGH = 8'h08;
    localparam logic [7:0] RXESB_REG_INT_STATUS = 8'h0C;
    localparam logic [7:0] RXESB_REG_INT_MASK = 8'h10;
    localparam logic [7:0] RXESB_REG_PTR_STATUS = 8'h14;
    localparam logic [7:0] RXESB_REG_SLIP_COUNT = 8'h18;

    // field positions
    localparam int RXESB_CTRL_SIZE_LSB = 0;
    localparam int RXESB_CTRL_CTM_BIT = 2;
    localparam int RXESB_CTRL_SYNC_OUT_BIT = 3;
    localparam int RXESB_INT_POS_BIT = 0;
    localparam int RXESB_INT_NEG_BIT = 1;
    localparam int RXESB_PTR_RD_LSB = 16;

    // reset values
    localparam logic [3:0] RXESB_CTRL_RST = 4'h0;
    localparam logic [7:0] RXESB_OFS_LOW_RST = 8'h00;
    localparam logic [1:0] RXESB_OFS_HIGH_RST = 2'h0;
    localparam logic [1:0] RXESB_INT_MASK_RST = 2'h3;

endpackage : rxesb_pkg

/* design/rxesb_sync.sv */
// two-stage synchroniser with rising-edge detect for outside inputs
`timescale 1ns/1ps
module rxesb_sync #(
    parameter int W = 1
) (
    input wire logic clk,           // block clock
    input wire logic rst,           // async reset, high
    input wire logic [W-1:0] din,   // asynchronous inputs
    output logic [W-1:0] dout,      // synchronised level
    output logic [W-1:0] rise       // one-cycle rising edge
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign dout = sync_q;
    assign rise = sync_q & ~prev_q;
endmodule : rxesb_sync

/* design/rxesb_mem.sv */
// circular bit store with one write port and one combinational read port
`timescale 1ns/1ps
module rxesb_mem #(
    parameter int DEPTH = 386,
    parameter int AW = 9
) (
    input wire logic clk,             // block clock
    input wire logic we,              // write strobe
    input wire logic [AW-1:0] waddr,  // write bit position
    input wire logic wdata,           // bit written
    input wire logic [AW-1:0] raddr,  // read bit position
    output logic rdata                // bit read
);
    logic store [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_bad_depth
        $error("rxesb_mem: depth does not fit address width");
    end

    always_ff @(posedge clk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
    end

    assign rdata = store[raddr];
endmodule : rxesb_mem

/* sim/rxesb_top_monitor.sv */
// concurrent checks on the elastic buffer top-level ports
`timescale 1ns/1ps
module rxesb_top_monitor #(
    parameter int SLIP_LIMIT = 8
) (
    input wire logic MCLK, // clock
    input wire logic SYS_RST, // reset
    input wire logic PSEL, // apb
    input wire logic PENABLE, // apb
    input wire logic PWRITE, // apb
    input wire logic [7:0] PADDR, // apb
    input wire logic [31:0] PWDATA, // apb
    input wire logic [31:0] PRDATA, // apb
    input wire logic PREADY, // apb
    input wire logic PSLVERR, // apb
    input wire logic RX_ROUTE_CLK, // line clock
    input wire logic RX_LINE_DATA, // line data
    input wire logic RX_SYSTEM_CLOCK, // highway clock
    input wire logic RX_FRAME_SYNC_PULSE_I, // sync in
    input wire logic RX_FRAME_SYNC_PULSE_O, // sync out
    input wire logic RX_FRAME_SYNC_PULSE_OE, // sync drive
    input wire logic RX_DATA_OUT, // data out
    input wire logic RX_SLIP_IRQ // interrupt
);
    import rxesb_pkg::*;
    logic wr_acc;
    logic [1:0] size_q;
    assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
    // shadow of the size field
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            size_q <= 2'b00;
        end else if (wr_acc && PADDR == RXESB_REG_CTRL) begin
            size_q <= PWDATA[1:0];
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    ready_single_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    err_unmapped_a: assert property (PSEL && !PENABLE && PADDR > RXESB_REG_SLIP_COUNT
        |=> PSLVERR && PRDATA == 32'h0000_0000) else $error("unmapped access not refused");
    mapped_ok_a: assert property (PSEL && !PENABLE && PADDR <= RXESB_REG_SLIP_COUNT
        && PADDR[1:0] == 2'b00 |=> !PSLVERR) else $error("mapped access refused");
    mask_quiet_a: assert property (wr_acc && PADDR == RXESB_REG_INT_MASK
        && PWDATA[1:0] == 2'b11 |-> ##2 !RX_SLIP_IRQ [*3]) else $error("masked irq high");
    irq_clear_a: assert property (wr_acc && PADDR == RXESB_REG_INT_STATUS
        && PWDATA[1:0] == 2'b11 |-> ##2 !RX_SLIP_IRQ) else $error("irq not cleared");
    sync_dir_a: assert property (wr_acc && PADDR == RXESB_REG_CTRL
        |-> ##2 RX_FRAME_SYNC_PULSE_OE == $past(PWDATA[3], 2)) else $error("bad sync enable");
    bypass_data_a: assert property (size_q == 2'b11 && $rose(RX_ROUTE_CLK) |-> ##5
        (size_q != 2'b11 || RX_DATA_OUT == $past(RX_LINE_DATA, 5)))
        else $error("bypass data wrong");
    cover property (RX_SLIP_IRQ);
    cover property (PSLVERR);
    cover property (size_q == 2'b11 && $rose(RX_ROUTE_CLK));
endmodule : rxesb_top_monitor

/* sim/rxesb_sys_model.sv */
// system highway model: clock source, sync pulse and frame capture
`timescale 1ns/1ps
module rxesb_sys_model (
    input wire logic run, // clock enable
    input int half_ns, // half period
    output logic sys_clk, // highway clock
    output logic sync_pulse, // own sync pulse
    input wire logic data_in, // serial data
    input wire logic sync_in, // sync pin level
    output logic [255:0] frame_q, // last whole frame
    output int frame_cnt // frames captured
);
    logic [255:0] shift_q;
    int idx;
    int gen_idx;
    initial begin
        sys_clk = 1'b0;
        sync_pulse = 1'b0;
        frame_q = '1;
        shift_q = '1;
        frame_cnt = 0;
        idx = 300;
        gen_idx = 0;
        forever begin
            if (run) begin
                #(half_ns) sys_clk = 1'b1;
                sync_pulse = (gen_idx == 0);
                gen_idx = (gen_idx + 1) % 256;
                #(half_ns) sys_clk = 1'b0;
                if (sync_in) begin
                    if (idx == 256) begin
                        frame_q = shift_q;
                        frame_cnt++;
                    end
                    idx = 0;
                end
                if (idx < 256) begin
                    shift_q[idx] = data_in;
                    idx++;
                end
            end else begin
                #10;
            end
        end
    end
endmodule : rxesb_sys_model

/* sim/tb_top.sv */
// bench: registers, slot translation, slips, interrupt, bypass, reset
`timescale 1ns/1ps
module tb_top;
    import rxesb_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} rxesb_row_s;
    logic MCLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, run, line_en;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd, base;
    logic RX_ROUTE_CLK, RX_LINE_DATA, RX_SYSTEM_CLOCK, RX_FRAME_SYNC_PULSE_I;
    logic RX_FRAME_SYNC_PULSE_O, RX_FRAME_SYNC_PULSE_OE, RX_DATA_OUT, RX_SLIP_IRQ, sync_drv, b;
    logic [15:0] pat;
    logic [255:0] frame_q, ef;
    int half_ns, frame_cnt, error_cnt, total_checks, m, k;
    rxesb_row_s rows [6] = '{'{RXESB_REG_CTRL, 32'(RXESB_CTRL_RST), 1'b0},
        '{RXESB_REG_OFS_LOW, 32'(RXESB_OFS_LOW_RST), 1'b0},
        '{RXESB_REG_OFS_HIGH, 32'(RXESB_OFS_HIGH_RST), 1'b0},
        '{RXESB_REG_INT_STATUS, 32'h0000_0000, 1'b0},
        '{RXESB_REG_INT_MASK, 32'(RXESB_INT_MASK_RST), 1'b0}, '{8'h1C, 32'h0000_0000, 1'b1}};
    assign RX_FRAME_SYNC_PULSE_I = RX_FRAME_SYNC_PULSE_OE ? RX_FRAME_SYNC_PULSE_O : sync_drv;
    rxesb_top rxesb_top_inst (.*);
    rxesb_sys_model rxesb_sys_model_inst (.run(run), .half_ns(half_ns),
        .sys_clk(RX_SYSTEM_CLOCK), .sync_pulse(sync_drv), .data_in(RX_DATA_OUT),
        .sync_in(RX_FRAME_SYNC_PULSE_I), .frame_q(frame_q), .frame_cnt(frame_cnt));
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    initial begin
        RX_ROUTE_CLK = 1'b0;
        forever #62.5 RX_ROUTE_CLK = ~RX_ROUTE_CLK;
    end
    // line data moves away from the sampled route edge
    always @(negedge RX_ROUTE_CLK) begin
        pat <= {pat[14:0], pat[15]};
        RX_LINE_DATA <= line_en & pat[15];
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : chk
    task automatic hang(input string what);
        $display("CHECK FAILED %s expected event seen timeout", what);
        error_cnt++;
        summarize();
    endtask : hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge MCLK);
            if (PREADY === 1'b1) break;
        end
        if (n == 16) hang("pready");
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wait_irq();
        int n;
        for (n = 0; n < 20000 && RX_SLIP_IRQ !== 1'b1; n++) @(posedge MCLK);
        if (n == 20000) hang("slip irq");
        run = 1'b0;
        repeat (20) @(posedge MCLK);
    endtask : wait_irq
    function automatic logic [255:0] exp_frame(input logic ctm);
        logic [255:0] e;
        for (int i = 0; i < 256; i++) begin
            if (i < 8) e[i] = (i != 0);
            else if (ctm) e[i] = (i / 8 > 24);
            else e[i] = (i / 8 % 4 == 0);
        end
        return e;
    endfunction : exp_frame
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, run, line_en, RX_LINE_DATA} = '0;
        SYS_RST = 1'b1;
        half_ns = 47;
        pat = 16'hB38E;
        repeat (10) @(posedge MCLK);
        SYS_RST <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk("read data", rows[i].d, rd);
            chk("slave error", 32'(rows[i].e), 32'(er));
        end
        $display("test registers done");
        run = 1'b1;
        apb(1'b1, RXESB_REG_OFS_LOW, 32'h0000_0008);
        // third pass: two-frame buffer, sync as input, offset of one slot
        for (m = 0; m < 3; m++) begin
            apb(1'b1, RXESB_REG_CTRL, m == 2 ? 32'h0000_0000
                : (m == 1 ? 32'h0000_000C : 32'h0000_0008));
            k = frame_cnt;
            for (int n = 0; n < 20000 && frame_cnt < k + 3; n++) @(posedge MCLK);
            if (frame_cnt < k + 3) hang("frames");
            ef = exp_frame(m == 1);
            if (m == 2) ef = {ef[7:0], ef[255:8]};
            for (k = 0; k < 8; k++) begin
                chk("frame word", ef[k*32+:32], frame_q[k*32+:32]);
            end
            $display("test translation mode %0d done", m);
        end
        // sync as output in short buffer
        apb(1'b1, RXESB_REG_CTRL, 32'h0000_000A);
        // drop flags and record the counts left by the start-up slip
        apb(1'b1, RXESB_REG_INT_STATUS, 32'h0000_0003);
        apb(1'b0, RXESB_REG_SLIP_COUNT, 32'h0000_0000);
        base = rd;
        apb(1'b1, RXESB_REG_INT_MASK, 32'h0000_0000);
        half_ns = 40;
        wait_irq();
        apb(1'b0, RXESB_REG_INT_STATUS, 32'h0000_0000);
        chk("positive flag", 32'h0000_0001, rd);
        apb(1'b0, RXESB_REG_SLIP_COUNT, 32'h0000_0000);
        chk("slip count", base + 32'h0000_0001, rd);
        apb(1'b1, RXESB_REG_INT_MASK, 32'h0000_0003);
        repeat (2) @(posedge MCLK);
        chk("masked irq", 32'h0000_0000, 32'(RX_SLIP_IRQ));
        apb(1'b0, RXESB_REG_INT_STATUS, 32'h0000_0000);
        chk("sticky flag", 32'h0000_0001, rd);
        apb(1'b1, RXESB_REG_INT_STATUS, 32'h0000_0003);
        apb(1'b0, RXESB_REG_INT_STATUS, 32'h0000_0000);
        chk("cleared flag", 32'h0000_0000, rd);
        apb(1'b1, RXESB_REG_INT_MASK, 32'h0000_0000);
        half_ns = 55;
        run = 1'b1;
        wait_irq();
        apb(1'b0, RXESB_REG_INT_STATUS, 32'h0000_0000);
        chk("negative flag", 32'h0000_0002, rd);
        apb(1'b0, RXESB_REG_SLIP_COUNT, 32'h0000_0000);
        chk("slip count", base + 32'h0000_0101, rd);
        apb(1'b1, RXESB_REG_INT_STATUS, 32'h0000_0003);
        $display("test slips done");
        apb(1'b1, RXESB_REG_CTRL, 32'h0000_0003);
        apb(1'b1, RXESB_REG_OFS_LOW, 32'h0000_005A);
        apb(1'b0, RXESB_REG_OFS_LOW, 32'h0000_0000);
        chk("offset in bypass", 32'h0000_0008, rd);
        line_en = 1'b1;
        half_ns = 30;
        run = 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge RX_ROUTE_CLK);
            b = RX_LINE_DATA;
            @(negedge RX_ROUTE_CLK);
            chk("bypass bit", 32'(b), 32'(RX_DATA_OUT));
        end
        apb(1'b0, RXESB_REG_INT_STATUS, 32'h0000_0000);
        chk("no slip in bypass", 32'h0000_0000, rd);
        $display("test bypass done");
        SYS_RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        chk("reset data", 32'h0000_0001, 32'(RX_DATA_OUT));
        chk("reset irq", 32'h0000_0000, 32'(RX_SLIP_IRQ));
        SYS_RST <= 1'b0;
        apb(1'b0, RXESB_REG_INT_MASK, 32'h0000_0000);
        chk("reset mask", 32'(RXESB_INT_MASK_RST), rd);
        $display("test reset done");
        summarize();
    end
endmodule : tb_top
bind rxesb_top rxesb_top_monitor #(.SLIP_LIMIT(SLIP_LIMIT)) rxesb_top_monitor_inst (.*);
